// File: inc/lane_path_defines.svh
`ifndef LANE_PATH_DEFINES_SVH
`define LANE_PATH_DEFINES_SVH
// Behaviour
// - Receive strips control, idle and compensation blocks before presenting data.
// - Receive stream has no ready input and no user-data buffer.
// - Receive valid comes with first word, receive last with final word.
// - Receive keep counts valid final-word bytes, as transmit keep, only with last.
// - With CRC on, receiver checks CRC and strips it before last is placed.
// - Receive valid may drop anywhere, even mid-frame, and resume later.
// - Transmit word taken on the edge where ready and valid are high.
// - Transmit ready drops one cycle in every 32 for the gearbox.
// - Three-cycle compensation sequence every 10,000 cycles pauses transmit data.
// - Strict alignment: no data block after idle or separator in one cycle.
// - Exactly full last block is closed by an empty separator next cycle.
// - Streaming delivers words in order, fixed latency, no delimiters.
// - Streaming ready stays high except during gearbox pause, compensation or channel not ready.
// - Streaming gaps reappear at receiver, except near compensation sequences.
// - Transmit keep read only with last; valid bytes packed from byte 0.
// - Each block is a two-bit header plus eight scrambled bytes.
// - A separator block carries a count of valid tail bytes.

`define AXI_AW 4
`define CTRL_ADDR 4'h0
`define STATUS_ADDR 4'h4
`define RXFRAMES_ADDR 4'h8
`define CTRL_ENABLE 0
`define CTRL_STREAM 1
`define CTRL_CRC 2
`define CTRL_RESET 3'h0
`define STAT_READY 0
`define STAT_TXFRAME 1
`define STAT_CRCERR 2
`define STAT_CC 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define HDR_DATA 2'h1
`define HDR_CTRL 2'h2
`define BT_IDLE 8'h10
`define BT_CC 8'h20
`define BT_SEP 8'h1e
`define BT_SEP7 8'h2e
`define BT_CRC 8'h3c
`define FULL_KEEP 8'hff
`define FULL_COUNT 4'h8
`define SEP7_COUNT 4'h7
`define CRC_POLY 32'h04c11db7
`define CRC_INIT 32'hffffffff
`define SCR_TAP_A 57
`define SCR_TAP_B 38
`define SCR_SEED 58'h3ff_ffff_ffff_ffff
`define GEAR_PERIOD 32
`define CC_PERIOD_CYCLES 10000
`define CC_LENGTH 3
`endif

// File: inc/lane_path_pkg.sv
package lane_path_pkg;
  typedef enum logic [1:0]
  {
    NORMAL_ST = 2'b00,
    EMPTY_SEPARATOR_BLOCK_ST = 2'b01,
    CRC_ST = 2'b10
  } tx_state_type;
endpackage

// File: design/lane_scrambler.sv
`timescale 1ns/1ns
`include "lane_path_defines.svh"
module lane_scrambler #(parameter bit DESCRAMBLE = 1'b0)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Block payload
  input wire logic advance,
  input wire logic [63:0] dataIn,
  output logic [63:0] dataOut
);
  logic [57:0] state_reg;
  logic [57:0] state_next;

  // Self-synchronous, so the receiver locks after one block of history
  always_comb
  begin
    state_next = state_reg;
    dataOut = 64'h0;
    for (int i = 0; i < 64; i++)
    begin
      dataOut[i] = dataIn[i] ^ state_next[`SCR_TAP_A]
        ^ state_next[`SCR_TAP_B];
      state_next = {state_next[56:0],
        DESCRAMBLE ? dataIn[i] : dataOut[i]};
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state_reg <= `SCR_SEED;
    else if (advance)
      state_reg <= state_next;
  end
endmodule

// File: design/pause_scheduler.sv
`timescale 1ns/1ns
`include "lane_path_defines.svh"
module pause_scheduler #(
  parameter int GEAR_PERIOD = `GEAR_PERIOD,
  parameter int CC_PERIOD = `CC_PERIOD_CYCLES,
  parameter int CC_LENGTH = `CC_LENGTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Schedule
  input wire logic run,
  output logic gearPause,
  output logic ccRequest
);
  localparam int GW = $clog2(GEAR_PERIOD);
  localparam int CW = $clog2(CC_PERIOD);
  logic [GW-1:0] gearCount_reg;
  logic [CW-1:0] ccCount_reg;
  wire ccWrap = ccCount_reg == CW'(CC_PERIOD - 1);

  assign gearPause = run && gearCount_reg == GW'(GEAR_PERIOD - 1);
  assign ccRequest = run && ccCount_reg < CW'(CC_LENGTH);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      gearCount_reg <= '0;
      ccCount_reg <= '0;
    end
    else if (!run)
    begin
      gearCount_reg <= '0;
      ccCount_reg <= '0;
    end
    else
    begin
      gearCount_reg <= gearPause ? '0 : gearCount_reg + 1'b1;
      ccCount_reg <= ccWrap ? '0 : ccCount_reg + 1'b1;
    end
  end

  gear_period_a: assert property (@(posedge ref_clk)
    disable iff (reset || !run) gearPause |-> ##32 gearPause)
    else $error("gearbox pause not every 32 cycles");
  gear_single_a: assert property (@(posedge ref_clk)
    disable iff (reset) gearPause |=> !gearPause)
    else $error("gearbox pause longer than one cycle");
  cc_length_a: assert property (@(posedge ref_clk)
    disable iff (reset || !run)
    $rose(ccRequest) |-> ccRequest [*3] ##1 !ccRequest)
    else $error("compensation not three cycles");
endmodule

// File: design/serial_lane_user_data_path.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "lane_path_defines.svh"
module serial_lane_user_data_path
  import lane_path_pkg::*;
#(
  parameter int CC_PERIOD = `CC_PERIOD_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus, AXI4-Lite
  input wire logic [`AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmit stream
  input wire logic [63:0] txData,
  input wire logic [7:0] txKeep,
  input wire logic txLast,
  input wire logic txValid,
  output logic txReady,
  // Receive stream
  output logic [63:0] rxData,
  output logic [7:0] rxKeep,
  output logic rxLast,
  output logic rxValid,
  // Lane
  input wire logic laneUp,
  output logic laneTxValid,
  output logic [1:0] laneTxHeader,
  output logic [63:0] laneTxPayload,
  input wire logic laneRxValid,
  input wire logic [1:0] laneRxHeader,
  input wire logic [63:0] laneRxPayload,
  // Status
  output logic clkCompRequest
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic upMeta_reg, upMid_reg, upLate_reg, laneUpSeen_reg;
  logic [2:0] ctrl_reg;
  logic crcError_reg;
  logic [31:0] rxFrames_reg;
  logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
  logic [`AXI_AW-1:0] awAddr_reg;
  logic [31:0] wData_reg, rdata_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  tx_state_type txState_reg, txState_next;
  logic txInFrame_reg;
  logic [31:0] crcTx_reg;
  logic laneTxValid_reg;
  logic [1:0] laneTxHeader_reg;
  logic [63:0] laneTxPayload_reg;
  logic pendValid_reg, pendLast_reg;
  logic [63:0] pendData_reg;
  logic [7:0] pendKeep_reg;
  logic rxInFrame_reg;
  logic [31:0] rxCrc_reg;
  logic rxValid_reg, rxLast_reg;
  logic [63:0] rxData_reg;
  logic [7:0] rxKeep_reg;
  logic gearPause, ccRequest;
  logic [63:0] txMasked, txPlain, txScrambled, rxPlain;
  logic [1:0] txHeader;

  function automatic logic [31:0] crcStep(input logic [31:0] c,
                                          input logic [63:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 64; i++)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `CRC_POLY : 32'h0);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------
  wire channelReady = laneUpSeen_reg & ctrl_reg[`CTRL_ENABLE];
  wire streamMode = ctrl_reg[`CTRL_STREAM];
  // Mode bits should only change while the channel is disabled
  wire crcOn = ctrl_reg[`CTRL_CRC] & ~streamMode;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      upMeta_reg <= 1'b0;
      upMid_reg <= 1'b0;
      upLate_reg <= 1'b0;
      laneUpSeen_reg <= 1'b0;
    end
    else
    begin
      upMeta_reg <= laneUp;
      upMid_reg <= upMeta_reg;
      upLate_reg <= upMid_reg;
      if (upMid_reg == upLate_reg)
        laneUpSeen_reg <= upLate_reg;
    end
  end

  pause_scheduler #(.CC_PERIOD(CC_PERIOD)) schedule
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(channelReady),
    .gearPause(gearPause),
    .ccRequest(ccRequest)
  );
  assign clkCompRequest = ccRequest;

  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  // Ready only in the plain state: empty separators and CRC need their own cycles
  assign txReady = channelReady & ~gearPause & ~ccRequest
    & (txState_reg == NORMAL_ST);
  wire txFire = txReady & txValid;
  wire txFrame = txFire & ~streamMode;
  wire [3:0] keepCount = 4'($countones(txKeep));
  wire tailFull = txLast & (keepCount == `FULL_COUNT);
  wire tailSep7 = txLast & (keepCount == `SEP7_COUNT);
  wire sendValid = channelReady & ~gearPause;
  wire sendCtl = sendValid & ~ccRequest;

  for (genvar b = 0; b < 8; b++)
  begin : gen_mask
    assign txMasked[8*b +: 8] = (txKeep[b] | ~txLast)
      ? txData[8*b +: 8] : 8'h00;
  end

  // One block a cycle on the single lane, so a separator never shares
  // its cycle with a following data block
  wire dataBlk = txFire & (streamMode | ~txLast | tailFull);
  wire [63:0] sepBlk = {txMasked[47:0], 4'h0, keepCount,
    `BT_SEP};
  wire [63:0] sep7Blk = {txMasked[55:0], `BT_SEP7};
  wire [63:0] sep0Blk = {56'h0, `BT_SEP};
  wire [63:0] crcBlk = {24'h0, crcTx_reg, `BT_CRC};
  wire [63:0] tailBlk = tailSep7 ? sep7Blk : sepBlk;
  wire [63:0] frameBlk = dataBlk ? txData
    : (txFire ? tailBlk : {56'h0, `BT_IDLE});
  wire [63:0] stateBlk = (txState_reg == EMPTY_SEPARATOR_BLOCK_ST) ? sep0Blk
    : (txState_reg == CRC_ST) ? crcBlk : frameBlk;
  assign txPlain = ccRequest ? {56'h0, `BT_CC} : stateBlk;
  assign txHeader = (dataBlk & ~ccRequest) ? `HDR_DATA
    : `HDR_CTRL;

  always_comb
  begin
    txState_next = txState_reg;
    case (txState_reg)
      NORMAL_ST:
        if (txFrame & txLast)
          txState_next = tailFull ? EMPTY_SEPARATOR_BLOCK_ST
            : (crcOn ? CRC_ST : NORMAL_ST);
      EMPTY_SEPARATOR_BLOCK_ST:
        if (sendCtl)
          txState_next = crcOn ? CRC_ST : NORMAL_ST;
      CRC_ST:
        if (sendCtl)
          txState_next = NORMAL_ST;
      default:
        txState_next = NORMAL_ST;
    endcase
  end

  lane_scrambler #(.DESCRAMBLE(1'b0)) txScrambler
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .advance(sendValid),
    .dataIn(txPlain),
    .dataOut(txScrambled)
  );

  wire [31:0] crcTxBase = txInFrame_reg ? crcTx_reg : `CRC_INIT;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      txState_reg <= NORMAL_ST;
      txInFrame_reg <= 1'b0;
      crcTx_reg <= `CRC_INIT;
      laneTxValid_reg <= 1'b0;
      laneTxHeader_reg <= `HDR_CTRL;
      laneTxPayload_reg <= 64'h0;
    end
    else
    begin
      txState_reg <= channelReady ? txState_next : NORMAL_ST;
      if (!channelReady)
        txInFrame_reg <= 1'b0;
      else if (txFrame)
        txInFrame_reg <= ~txLast;
      if (txFrame)
        crcTx_reg <= crcStep(crcTxBase, txMasked);
      laneTxValid_reg <= sendValid;
      laneTxHeader_reg <= txHeader;
      laneTxPayload_reg <= txScrambled;
    end
  end

  assign laneTxValid = laneTxValid_reg;
  assign laneTxHeader = laneTxHeader_reg;
  assign laneTxPayload = laneTxPayload_reg;

  // ----------------------------------------------------------------
  // Receive
  // ----------------------------------------------------------------
  lane_scrambler #(.DESCRAMBLE(1'b1)) rxDescrambler
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .advance(laneRxValid),
    .dataIn(laneRxPayload),
    .dataOut(rxPlain)
  );

  wire [7:0] rxType = rxPlain[7:0];
  wire rxIsData = laneRxValid & (laneRxHeader == `HDR_DATA);
  wire rxIsCtrl = laneRxValid & (laneRxHeader == `HDR_CTRL);
  wire rxIsSep = rxIsCtrl & (rxType == `BT_SEP);
  wire [3:0] rxSepCount = rxPlain[11:8];
  wire rxIsSep0 = rxIsSep & (rxSepCount == 4'h0);
  wire rxIsSep7 = rxIsCtrl & (rxType == `BT_SEP7);
  wire rxIsCrc = rxIsCtrl & (rxType == `BT_CRC);
  wire rxTail = (rxIsSep & ~rxIsSep0) | rxIsSep7;
  wire [3:0] tailCount = rxIsSep7 ? `SEP7_COUNT : rxSepCount;
  wire [7:0] tailKeep = 8'(`FULL_KEEP
    >> (`FULL_COUNT - tailCount));
  wire [63:0] tailData = rxIsSep7 ? {8'h0, rxPlain[63:8]}
    : {16'h0, rxPlain[63:16]};
  // Idle and compensation blocks never load the word slot
  wire rxTake = rxIsData | rxTail;
  wire [63:0] rxWord = rxTail ? tailData : rxPlain;
  wire pendDone = pendLast_reg & (~crcOn | rxIsCrc);
  // No ready input: a word leaves as soon as its successor is known
  wire emitPend = pendValid_reg & (rxTake | pendDone);
  wire crcBad = rxIsCrc & pendLast_reg
    & (rxPlain[39:8] != rxCrc_reg);
  wire [31:0] crcRxBase = rxInFrame_reg ? rxCrc_reg : `CRC_INIT;
  wire streamOut = streamMode & rxIsData;
  wire frameOut = ~streamMode & emitPend;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pendValid_reg <= 1'b0;
      pendLast_reg <= 1'b0;
      pendData_reg <= 64'h0;
      pendKeep_reg <= `FULL_KEEP;
    end
    else if (!channelReady || streamMode)
    begin
      pendValid_reg <= 1'b0;
      pendLast_reg <= 1'b0;
    end
    else if (rxTake)
    begin
      pendValid_reg <= 1'b1;
      pendLast_reg <= rxTail;
      pendData_reg <= rxWord;
      pendKeep_reg <= rxTail ? tailKeep : `FULL_KEEP;
    end
    else if (emitPend)
    begin
      pendValid_reg <= 1'b0;
      pendLast_reg <= 1'b0;
    end
    else if (rxIsSep0 & pendValid_reg)
      pendLast_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rxInFrame_reg <= 1'b0;
      rxCrc_reg <= `CRC_INIT;
      rxValid_reg <= 1'b0;
      rxLast_reg <= 1'b0;
      rxData_reg <= 64'h0;
      rxKeep_reg <= `FULL_KEEP;
    end
    else
    begin
      if (rxTake)
      begin
        rxInFrame_reg <= rxIsData;
        rxCrc_reg <= crcStep(crcRxBase, rxWord);
      end
      // An empty separator closes a frame without loading a word
      else if (rxIsSep0 || !channelReady)
        rxInFrame_reg <= 1'b0;
      rxValid_reg <= channelReady & (streamOut | frameOut);
      rxLast_reg <= ~streamMode & pendLast_reg & pendDone;
      rxData_reg <= streamMode ? rxPlain : pendData_reg;
      rxKeep_reg <= streamMode ? `FULL_KEEP : pendKeep_reg;
    end
  end

  assign rxValid = rxValid_reg;
  assign rxLast = rxLast_reg;
  assign rxData = rxData_reg;
  assign rxKeep = rxKeep_reg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign s_axi_awready = ~awHeld_reg & ~bvalid_reg;
  assign s_axi_wready = ~wHeld_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  wire wrGo = awHeld_reg & wHeld_reg & ~bvalid_reg;
  wire wrCtrl = wrGo & (awAddr_reg == `CTRL_ADDR) & wStrb_reg[0];
  wire wrStatus = wrGo & (awAddr_reg == `STATUS_ADDR) & wStrb_reg[0];
  wire wrMapped = (awAddr_reg == `CTRL_ADDR)
    | (awAddr_reg == `STATUS_ADDR) | (awAddr_reg == `RXFRAMES_ADDR);
  wire rdGo = s_axi_arvalid & ~rvalid_reg;
  wire [31:0] statusWord = {28'h0, ccRequest, crcError_reg,
    txInFrame_reg, channelReady};
  wire rdCtrl = s_axi_araddr == `CTRL_ADDR;
  wire rdStatus = s_axi_araddr == `STATUS_ADDR;
  wire rdFrames = s_axi_araddr == `RXFRAMES_ADDR;
  wire [31:0] rdWord = rdCtrl ? {29'h0, ctrl_reg}
    : rdStatus ? statusWord : rdFrames ? rxFrames_reg : 32'h0;
  wire clearCrcErr = wrStatus & wData_reg[`STAT_CRCERR];

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      awAddr_reg <= '0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrGo)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET;
      crcError_reg <= 1'b0;
      rxFrames_reg <= 32'h0;
    end
    else
    begin
      if (rdGo)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdWord;
        rresp_reg <= (rdCtrl | rdStatus | rdFrames)
          ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
      if (wrCtrl)
        ctrl_reg <= wData_reg[2:0];
      // A mismatch in the clearing cycle still sets the flag
      crcError_reg <= crcBad | (crcError_reg & ~clearCrcErr);
      if (rxValid_reg & rxLast_reg)
        rxFrames_reg <= rxFrames_reg + 32'h1;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence fullTailSeq;
    txFrame & txLast & (txKeep == `FULL_KEEP) & ~ccRequest;
  endsequence
  sequence ctrlBlockSeq;
    laneTxValid & (laneTxHeader == `HDR_CTRL);
  endsequence

  ready_gated_a: assert property (!channelReady |-> !txReady)
    else $error("transmit ready while channel down");
  rx_gated_a: assert property (!channelReady |=> !rxValid)
    else $error("receive valid while channel down");
  data_block_a: assert property (
    (txFire & (streamMode | ~txLast) & ~ccRequest)
    |=> laneTxValid & (laneTxHeader == `HDR_DATA))
    else $error("accepted word not sent as data block");
  empty_separator_block_close_a: assert property (fullTailSeq |=>
    laneTxValid & (laneTxHeader == `HDR_DATA)
    & (stateBlk == {56'h0, `BT_SEP}))
    else $error("full tail not closed by separator");
  stream_ready_a: assert property (
    streamMode & channelReady & ~gearPause & ~ccRequest |-> txReady)
    else $error("streaming ready dropped without cause");
  stream_latency_a: assert property (
    streamMode & channelReady & rxIsData |=> rxValid & !rxLast)
    else $error("streaming word not delivered next cycle");
  strip_ctrl_a: assert property (
    streamMode & ~rxIsData |=> !rxValid)
    else $error("control block reached receive stream");
  last_keep_a: assert property (
    rxValid & rxLast |-> rxKeep != 8'h00)
    else $error("last word with empty keep");
  crc_last_a: assert property (
    $past(crcOn) & rxValid & rxLast |-> $past(rxIsCrc))
    else $error("last placed before CRC check");
  idle_fill_a: assert property (
    txInFrame_reg & ~txValid & sendCtl & (txState_reg == NORMAL_ST)
    |=> ctrlBlockSeq)
    else $error("pause mid-frame did not send idle");
endmodule

// File: verif/rx_sink_model.sv
`timescale 1ns/1ns
module rx_sink_model
(
  // Clock
  input wire logic ref_clk,
  // Receive stream
  input wire logic [63:0] rxData,
  input wire logic [7:0] rxKeep,
  input wire logic rxLast,
  input wire logic rxValid
);
  logic [63:0] gotData[$];
  logic [7:0] gotKeep[$];
  logic gotLast[$];
  int gotTime[$];
  int cyc = 0;
  function automatic void clear();
    gotData.delete();
    gotKeep.delete();
    gotLast.delete();
    gotTime.delete();
  endfunction
  // No ready exists, so each word is taken in its own valid cycle
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (rxValid === 1'b1)
    begin
      gotData.push_back(rxData);
      gotKeep.push_back(rxKeep);
      gotLast.push_back(rxLast);
      gotTime.push_back(cyc);
    end
  end
endmodule

// File: verif/serial_lane_user_data_path_tb.sv
`timescale 1ns/1ns
`include "lane_path_defines.svh"
module serial_lane_user_data_path_tb import lane_path_pkg::*;;
  localparam int CCP = 400;
  logic ref_clk, reset, laneUp, txLast, txValid, txReady, rxLast, rxValid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, laneTxValid, clkCompRequest;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, laneTxHeader, resp;
  logic [63:0] txData, rxData, laneTxPayload;
  logic [7:0] txKeep, rxKeep;
  int num_errors = 0, n_tests = 0, cyc = 0, cnt, bad;
  int txTime[$];
  // Lane looped back onto itself
  serial_lane_user_data_path #(.CC_PERIOD(CCP)) DUT
  (
    .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .txData, .txKeep, .txLast, .txValid, .txReady, .rxData, .rxKeep, .rxLast,
    .rxValid, .laneUp, .laneTxValid, .laneTxHeader, .laneTxPayload,
    .laneRxValid(laneTxValid), .laneRxHeader(laneTxHeader),
    .laneRxPayload(laneTxPayload), .clkCompRequest
  );
  rx_sink_model sink (.ref_clk, .rxData, .rxKeep, .rxLast, .rxValid);
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // ----------------
  // Tasks
  // ----------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic limit(input int n);
    if (n >= 300)
    begin
      num_errors++;
      tally_and_finish;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 300);
    limit(n);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 300);
    limit(n);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Leaves valid up so back to back words need no extra edge
  task automatic send(input logic [63:0] d, input logic [7:0] k, input logic l);
    int n;
    n = 0;
    txData <= d;
    txKeep <= k;
    txLast <= l;
    txValid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (txReady !== 1'b1 && n < 300);
    limit(n);
    txTime.push_back(cyc);
  endtask
  task automatic idle(input int n);
    txValid <= 1'b0;
    tick(n);
  endtask
  task automatic waitrx(input int k);
    int n;
    n = 0;
    while (sink.gotData.size() < k && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    limit(n);
    tick(3);
  endtask
  // Skips past one compensation burst, leaving a long quiet stretch
  task automatic waitcc;
    int n;
    n = 0;
    while (clkCompRequest !== 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      n++;
    end
    limit(n / 2);
    tick(4);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    reset = 1'b1;
    laneUp = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, txLast, txValid} = '0;
    s_axi_wstrb = 4'hf;
    txData = 64'h0;
    txKeep = 8'hff;
    tick(8);
    reset <= 1'b0;
    tick(4);
    axr(`CTRL_ADDR);
    check(64'(rd), 64'(`CTRL_RESET));
    axr(4'hc);
    check(64'({resp, rd}), 64'({`RESP_SLVERR, 32'h0}));
    axw(4'hc, 32'h1);
    check(64'(resp), 64'(`RESP_SLVERR));
    axw(`CTRL_ADDR, 32'h1);
    tick(20);
    check(64'({txReady, rxValid}), 64'h0);
    laneUp <= 1'b1;
    $display("registers and startup done");
    sink.clear();
    send(64'h0123_4567_89ab_cdef, 8'hff, 1'b0);
    send(64'h1122_3344_5566_7788, 8'hff, 1'b0);
    idle(3);
    send(64'h00ff_aa55_0aa0_5aa5, 8'h07, 1'b1);
    idle(1);
    waitrx(3);
    check(64'(sink.gotData.size()), 64'h3);
    check(sink.gotData[0], 64'h0123_4567_89ab_cdef);
    check(64'(sink.gotTime[1] - sink.gotTime[0] > 1), 64'h1);
    check(sink.gotData[1], 64'h1122_3344_5566_7788);
    check(sink.gotData[2] & 64'hff_ffff, 64'ha0_5aa5);
    check(64'({sink.gotLast[1], sink.gotLast[2]}), 64'h1);
    check(64'(sink.gotKeep[2]), 64'h07);
    sink.clear();
    send(64'h0f0f_0f0f_f0f0_f0f0, 8'hff, 1'b1);
    idle(1);
    check(64'({laneTxValid, laneTxHeader}), 64'(`HDR_DATA) | 64'h4);
    tick(1);
    check(64'({laneTxValid, laneTxHeader}), 64'(`HDR_CTRL) | 64'h4);
    waitrx(1);
    check(64'({sink.gotLast[0], sink.gotKeep[0]}), 64'h1ff);
    axr(`RXFRAMES_ADDR);
    check(64'(rd), 64'h2);
    $display("framing done");
    axw(`CTRL_ADDR, 32'h0);
    axw(`CTRL_ADDR, 32'h5);
    sink.clear();
    send(64'h2468_ace0_1357_9bdf, 8'hff, 1'b0);
    send(64'h7766_5544_3322_1100, 8'h0f, 1'b1);
    send(64'h00bb_ccdd_eeff_0011, 8'h7f, 1'b1);
    idle(1);
    waitrx(3);
    check(64'(sink.gotData.size()), 64'h3);
    check(sink.gotData[1] & 64'hffff_ffff, 64'h3322_1100);
    check(64'({sink.gotLast[1], sink.gotKeep[1]}), 64'h10f);
    check(sink.gotData[2], 64'h00bb_ccdd_eeff_0011);
    check(64'({sink.gotLast[2], sink.gotKeep[2]}), 64'h17f);
    axr(`STATUS_ADDR);
    check(64'(rd[`STAT_CRCERR]), 64'h0);
    $display("crc done");
    waitcc;
    cnt = 0;
    repeat (320)
    begin
      @(posedge ref_clk);
      if (txReady === 1'b0 && clkCompRequest === 1'b0) cnt++;
    end
    check(64'(cnt), 64'd10);
    cnt = 0;
    bad = 0;
    repeat (4 * CCP)
    begin
      @(posedge ref_clk);
      if (clkCompRequest === 1'b1) cnt++;
      if (clkCompRequest === 1'b1 && txReady !== 1'b0) bad++;
    end
    check(64'(cnt), 64'd12);
    check(64'(bad), 64'h0);
    $display("pauses done");
    axw(`CTRL_ADDR, 32'h0);
    axw(`CTRL_ADDR, 32'h3);
    waitcc;
    sink.clear();
    txTime.delete();
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2) idle(2);
      send(64'hfeed_0000_0000_0000 + 64'(i), 8'hff, 1'b0);
    end
    idle(1);
    waitrx(4);
    for (int i = 0; i < 4; i++)
    begin
      check(sink.gotData[i], 64'hfeed_0000_0000_0000 + 64'(i));
      check(64'(sink.gotLast[i]), 64'h0);
      if (i > 0)
        check(64'(sink.gotTime[i] - sink.gotTime[i - 1]),
          64'(txTime[i] - txTime[i - 1]));
    end
    $display("streaming done");
    tally_and_finish;
  end
endmodule
